/* File: common/gmx_pkg.sv */
// shared constants, signal codes and pin map for the pin mux and interrupt block
package gmx_pkg;

	localparam int NUM_PINS = 26;
	localparam int NUM_SIG = 24;
	localparam int NUM_WAKE = 5;

	// function selector codes
	localparam logic [2:0] FSEL_GPIO = 3'h0;
	localparam logic [2:0] FSEL_ALT_A = 3'h1;
	localparam logic [2:0] FSEL_ALT_B = 3'h4;
	localparam logic [2:0] FSEL_ALT_C = 3'h5;

	// reset values and fixed pin groups
	localparam logic [NUM_PINS-1:0] DIR_RST = 26'h000_0000;
	localparam logic [NUM_PINS-1:0] PULL_RST = 26'h3ff_cfff;
	localparam logic [NUM_PINS-1:0] INPUT_ONLY_PINS = 26'h000_3000;
	localparam logic [NUM_PINS-1:0] PAD_OUT_RST = 26'h000_0000;
	localparam logic [NUM_SIG-1:0] PERIPH_IN_RST = 24'hff_ffff;
	localparam int WAKE_PIN [NUM_WAKE] = '{9, 10, 11, 12, 13};

	// peripheral signal codes, also the index into the peripheral vectors
	typedef enum logic [4:0] {
		SIG_NONE = 5'h00, SIG_UART_CTS = 5'h01, SIG_UART_RTS = 5'h02, SIG_UART_TXD = 5'h03,
		SIG_UART_RXD = 5'h04, SIG_SPI_CLK = 5'h05, SIG_SPI_SEL_ONE = 5'h06, SIG_SPI_DOUT = 5'h07,
		SIG_SPI_DIN = 5'h08, SIG_SPI_SEL_TWO = 5'h09, SIG_SPI_SEL_THREE = 5'h0a, SIG_I2C_ONE_CLK = 5'h0b,
		SIG_I2C_ONE_DAT = 5'h0c, SIG_I2C_TWO_CLK = 5'h0d, SIG_I2C_TWO_DAT = 5'h0e, SIG_PWM_A = 5'h0f,
		SIG_PWM_B = 5'h10, SIG_MIC_DIN = 5'h11, SIG_MIC_CLK = 5'h12, SIG_CORE_CLK = 5'h13,
		SIG_XTAL_CLK = 5'h14, SIG_SLOW_CLK = 5'h15, SIG_DBG_CLK = 5'h16, SIG_DBG_DAT = 5'h17
	} gmx_sig_t;

	typedef enum logic [1:0] {
		KIND_IN = 2'h0, KIND_OUT = 2'h1, KIND_IO = 2'h2, KIND_OD = 2'h3
	} gmx_kind_t;

	// columns: 0 = alternate set a (001), 1 = set b (100), 2 = set c (101)
	localparam gmx_sig_t PIN_MAP [NUM_PINS][3] = '{
		'{SIG_UART_CTS, SIG_SPI_CLK, SIG_CORE_CLK},
		'{SIG_UART_RTS, SIG_SPI_SEL_ONE, SIG_MIC_DIN},
		'{SIG_PWM_A, SIG_SPI_DOUT, SIG_MIC_CLK},
		'{SIG_PWM_B, SIG_SPI_DIN, SIG_NONE},
		'{SIG_UART_RXD, SIG_I2C_TWO_CLK, SIG_PWM_A},
		'{SIG_UART_TXD, SIG_I2C_TWO_DAT, SIG_PWM_B},
		'{SIG_UART_RTS, SIG_I2C_TWO_CLK, SIG_MIC_DIN},
		'{SIG_UART_CTS, SIG_I2C_TWO_DAT, SIG_MIC_CLK},
		'{SIG_UART_TXD, SIG_SPI_CLK, SIG_MIC_DIN},
		'{SIG_DBG_CLK, SIG_SPI_DIN, SIG_XTAL_CLK},
		'{SIG_DBG_DAT, SIG_SPI_DOUT, SIG_SLOW_CLK},
		'{SIG_UART_RXD, SIG_SPI_SEL_ONE, SIG_SLOW_CLK},
		'{SIG_NONE, SIG_I2C_ONE_CLK, SIG_NONE},
		'{SIG_UART_CTS, SIG_I2C_ONE_DAT, SIG_NONE},
		'{SIG_I2C_ONE_CLK, SIG_SPI_CLK, SIG_NONE},
		'{SIG_I2C_ONE_DAT, SIG_SPI_SEL_ONE, SIG_NONE},
		'{SIG_PWM_A, SIG_SPI_DIN, SIG_NONE},
		'{SIG_PWM_B, SIG_SPI_DOUT, SIG_NONE},
		'{SIG_SPI_SEL_TWO, SIG_UART_RTS, SIG_NONE},
		'{SIG_SPI_SEL_THREE, SIG_UART_CTS, SIG_NONE},
		'{SIG_UART_CTS, SIG_SPI_SEL_TWO, SIG_NONE},
		'{SIG_PWM_B, SIG_SPI_SEL_ONE, SIG_NONE},
		'{SIG_PWM_A, SIG_SPI_SEL_THREE, SIG_NONE},
		'{SIG_UART_TXD, SIG_SPI_DOUT, SIG_MIC_CLK},
		'{SIG_UART_RXD, SIG_SPI_DIN, SIG_MIC_DIN},
		'{SIG_UART_RTS, SIG_SPI_CLK, SIG_MIC_CLK}
	};

	// signal carried by a pin under a selector; unused codes give none
	function automatic gmx_sig_t gmx_pin_signal(input int pin, input logic [2:0] sel);
		case (sel)
			FSEL_ALT_A: gmx_pin_signal = PIN_MAP[pin][0];
			FSEL_ALT_B: gmx_pin_signal = PIN_MAP[pin][1];
			FSEL_ALT_C: gmx_pin_signal = PIN_MAP[pin][2];
			default: gmx_pin_signal = SIG_NONE;
		endcase
	endfunction : gmx_pin_signal

	// pad direction class of a peripheral signal
	function automatic gmx_kind_t gmx_sig_kind(input gmx_sig_t s);
		case (s)
			SIG_UART_CTS, SIG_UART_RXD, SIG_SPI_DIN, SIG_MIC_DIN, SIG_DBG_CLK, SIG_NONE: gmx_sig_kind = KIND_IN;
			SIG_SPI_CLK, SIG_SPI_SEL_ONE, SIG_DBG_DAT: gmx_sig_kind = KIND_IO;
			SIG_I2C_ONE_CLK, SIG_I2C_ONE_DAT, SIG_I2C_TWO_CLK, SIG_I2C_TWO_DAT: gmx_sig_kind = KIND_OD;
			default: gmx_sig_kind = KIND_OUT;
		endcase
	endfunction : gmx_sig_kind

endpackage : gmx_pkg

/* File: common/gmx_irq_if.sv */
// carrier between the pin mux and the interrupt detector
`timescale 1ns/10ps
interface gmx_irq_if;
	import gmx_pkg::*;

	logic [NUM_PINS-1:0] level;
	logic [NUM_PINS-1:0] trigger_kind_cfg;
	logic [NUM_PINS-1:0] dual_edge_cfg;
	logic [NUM_PINS-1:0] polarity_cfg;
	logic [NUM_PINS-1:0] enable;
	logic [NUM_PINS-1:0] clear;
	logic [NUM_PINS-1:0] raw;
	logic [NUM_PINS-1:0] masked;
	logic irq;

	modport det (
		input level, trigger_kind_cfg, dual_edge_cfg, polarity_cfg, enable, clear,
		output raw, masked, irq
	);
	modport mux (
		output level, trigger_kind_cfg, dual_edge_cfg, polarity_cfg, enable, clear,
		input raw, masked, irq
	);
endinterface : gmx_irq_if

/* File: design/gmx_irq_detect.sv */
// per-pin interrupt detector with raw and masked flags
`timescale 1ns/10ps
module gmx_irq_detect import gmx_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// detector side of the carrier
	gmx_irq_if.det irq
);

	logic [NUM_PINS-1:0] prev_ff;
	logic [1:0] warm_ff;
	logic armed_ff;
	logic [NUM_PINS-1:0] prev_raw_kept;
	logic [NUM_PINS-1:0] raw_ff;
	logic [NUM_PINS-1:0] masked_ff;
	logic irq_ff;
	logic [NUM_PINS-1:0] rise;
	logic [NUM_PINS-1:0] fall;
	logic [NUM_PINS-1:0] edge_hit;
	logic [NUM_PINS-1:0] level_hit;
	logic [NUM_PINS-1:0] match;
	logic [NUM_PINS-1:0] nxt_raw;

	// previous level; the two-stage synchroniser ahead shows reset zeros for two cycles,
	// so hits count only once both level and previous level are real samples (no false edge on pulled-up pins)
	always_ff @(posedge mclk) begin
		if (reset) begin
			prev_ff <= PAD_OUT_RST;
			warm_ff <= 2'h0;
			armed_ff <= 1'b0;
		end else begin
			prev_ff <= irq.level;
			warm_ff <= {warm_ff[0], 1'b1};
			armed_ff <= warm_ff[1];
		end
	end

	// trigger decode, independent of the pin function
	always_comb begin
		rise = irq.level & ~prev_ff;
		fall = ~irq.level & prev_ff;
		edge_hit = {NUM_PINS{armed_ff}} & ((irq.dual_edge_cfg & (rise | fall))
			| (~irq.dual_edge_cfg & irq.polarity_cfg & rise) | (~irq.dual_edge_cfg & ~irq.polarity_cfg & fall));
		level_hit = {NUM_PINS{armed_ff}} & ((irq.polarity_cfg & irq.level) | (~irq.polarity_cfg & ~irq.level));
		match = (irq.trigger_kind_cfg & level_hit) | (~irq.trigger_kind_cfg & edge_hit);
		// a hit in the same cycle as its clear still sets the flag
		nxt_raw = (raw_ff & ~irq.clear) | match;
	end

	// flags and combined line; masked view follows the enable mask
	always_ff @(posedge mclk) begin
		if (reset) begin
			raw_ff <= PAD_OUT_RST;
			masked_ff <= PAD_OUT_RST;
			irq_ff <= 1'b0;
		end else begin
			raw_ff <= nxt_raw;
			masked_ff <= nxt_raw & irq.enable;
			irq_ff <= |(nxt_raw & irq.enable);
		end
	end

	assign irq.raw = raw_ff;
	assign irq.masked = masked_ff;
	assign irq.irq = irq_ff;

	raw_set_a: assert property (@(posedge mclk) disable iff (reset)
		(match != '0) |=> ((raw_ff & $past(match)) == $past(match)))
		else $error("raw flag missed a trigger");
	clear_bit_a: assert property (@(posedge mclk) disable iff (reset)
		((irq.clear & ~match) != '0) |=> ((raw_ff & $past(irq.clear & ~match)) == '0))
		else $error("raw flag not cleared");
	clear_zero_a: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> ((raw_ff & $past(prev_raw_kept)) == $past(prev_raw_kept)))
		else $error("raw flag lost without a clear");
	masked_view_a: assert property (@(posedge mclk) disable iff (reset)
		masked_ff == (raw_ff & $past(irq.enable)))
		else $error("masked flags differ from raw and enable");
	irq_line_a: assert property (@(posedge mclk) disable iff (reset)
		irq_ff == (masked_ff != '0))
		else $error("combined line disagrees with masked flags");
	rise_edge_a: assert property (@(posedge mclk) disable iff (reset)
		(armed_ff && !irq.trigger_kind_cfg[0] && !irq.dual_edge_cfg[0] && !irq.polarity_cfg[0] && !prev_ff[0]
		&& irq.level[0] && !raw_ff[0]) |=> !raw_ff[0])
		else $error("falling-edge pin set on a rising edge");
	cover_edge_c: cover property (@(posedge mclk) disable iff (reset) (edge_hit != '0) ##1 irq_ff);
	cover_level_c: cover property (@(posedge mclk) disable iff (reset) (irq.trigger_kind_cfg & level_hit) != '0);
	cover_clear_c: cover property (@(posedge mclk) disable iff (reset) (irq.clear & raw_ff & match) != '0);

	// flags that survive this cycle's clear, watched by the assertion above
	assign prev_raw_kept = raw_ff & ~irq.clear;

endmodule : gmx_irq_detect

/* File: design/gmx_pin_mux.sv */
// pin function multiplexer with per-pin interrupts and wake-up requests
// How it works
// - three-bit selector: gpio or three alternate sets
// - alternate sets route serial lines per pin map
// - set c carries microphone clock and bitstream
// - two pwm sources on pins 2 to 5, 16, 17, 21 and 22
// - five pins raise wake-up requests
// - pins 12, 13 never drive in gpio
// - interrupts work whatever function is selected
// - edge or level sensing chosen per pin
// - decode sense, dual-edge and polarity bits
// - trigger match sets the raw flag
// - enable mask bit 1 enables pin interrupt
// - clear write of 1 clears, 0 ignored
// - all pins merge onto one interrupt line
// - core and crystal clock outputs need their enable bits set
// - reset leaves gpio input mode, pulls on except pins 12, 13
// - direction bit 0 input, 1 output, reset zero
`timescale 1ns/10ps
module gmx_pin_mux import gmx_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// package pads
	input wire logic [NUM_PINS-1:0] pad_in,
	output logic [NUM_PINS-1:0] pad_out,
	output logic [NUM_PINS-1:0] pad_oe,
	output logic [NUM_PINS-1:0] pad_pull_en,
	// pin configuration
	input wire logic [NUM_PINS-1:0][2:0] func_select,
	input wire logic [NUM_PINS-1:0] gpio_out_data,
	input wire logic [NUM_PINS-1:0] direction_select,
	input wire logic [NUM_PINS-1:0] pull_enable_cfg,
	input wire logic core_clock_pin_enable,
	input wire logic crystal_pin_enable,
	// pin levels as seen by software
	output logic [NUM_PINS-1:0] gpio_in_data,
	// on-chip peripherals, indexed by signal code
	input wire logic [NUM_SIG-1:0] periph_out,
	input wire logic [NUM_SIG-1:0] periph_oe,
	output logic [NUM_SIG-1:0] periph_in,
	// interrupt configuration and status
	input wire logic [NUM_PINS-1:0] trigger_kind_select,
	input wire logic [NUM_PINS-1:0] dual_edge_select,
	input wire logic [NUM_PINS-1:0] polarity_select,
	input wire logic [NUM_PINS-1:0] irq_enable_mask,
	input wire logic [NUM_PINS-1:0] irq_clear,
	output logic [NUM_PINS-1:0] raw_irq_flags,
	output logic [NUM_PINS-1:0] masked_irq_flags,
	output logic irq_line,
	// wake-up
	input wire logic [NUM_WAKE-1:0] wake_enable,
	output logic [NUM_WAKE-1:0] wake_req
);

	logic [NUM_PINS-1:0] pad_meta_ff;
	logic [NUM_PINS-1:0] pad_sync_ff;
	logic [NUM_PINS-1:0] gpio_in_ff;
	logic [NUM_PINS-1:0] pad_out_ff;
	logic [NUM_PINS-1:0] pad_oe_ff;
	logic [NUM_PINS-1:0] pull_ff;
	logic [NUM_SIG-1:0] periph_in_ff;
	logic [NUM_WAKE-1:0] wake_ff;
	logic [NUM_PINS-1:0] nxt_pad_out;
	logic [NUM_PINS-1:0] nxt_pad_oe;
	logic [NUM_SIG-1:0] nxt_periph_in;

	gmx_irq_if irq_bus ();

	// two-stage synchroniser; only the second stage feeds any logic
	always_ff @(posedge mclk) begin
		if (reset) begin
			pad_meta_ff <= PAD_OUT_RST;
			pad_sync_ff <= PAD_OUT_RST;
			gpio_in_ff <= PAD_OUT_RST;
		end else begin
			pad_meta_ff <= pad_in;
			pad_sync_ff <= pad_meta_ff;
			gpio_in_ff <= pad_sync_ff;
		end
	end

	// output mux: each pin picks gpio or the signal of its alternate column
	always_comb begin
		gmx_sig_t sig;
		sig = SIG_NONE;
		nxt_pad_out = PAD_OUT_RST;
		nxt_pad_oe = DIR_RST;
		for (int p = 0; p < NUM_PINS; p++) begin
			sig = gmx_pin_signal(p, func_select[p]);
			if (func_select[p] == FSEL_GPIO) begin
				nxt_pad_out[p] = gpio_out_data[p];
				nxt_pad_oe[p] = direction_select[p] & ~INPUT_ONLY_PINS[p];
			end else begin
				case (gmx_sig_kind(sig))
					KIND_OUT: begin
						nxt_pad_out[p] = periph_out[sig];
						nxt_pad_oe[p] = 1'b1;
					end
					KIND_IO: begin
						nxt_pad_out[p] = periph_out[sig];
						nxt_pad_oe[p] = periph_oe[sig];
					end
					KIND_OD: begin
						// open drain: only ever pull low, the bus pull-up makes the high
						nxt_pad_out[p] = 1'b0;
						nxt_pad_oe[p] = periph_oe[sig] & ~periph_out[sig];
					end
					default: begin
						nxt_pad_out[p] = 1'b0;
						nxt_pad_oe[p] = 1'b0;
					end
				endcase
				// core and crystal clocks stay off the pin until enabled
				if (sig == SIG_CORE_CLK) begin
					nxt_pad_oe[p] = core_clock_pin_enable;
					nxt_pad_out[p] = periph_out[sig] & core_clock_pin_enable;
				end else if (sig == SIG_XTAL_CLK) begin
					nxt_pad_oe[p] = crystal_pin_enable;
					nxt_pad_out[p] = periph_out[sig] & crystal_pin_enable;
				end
			end
		end
	end

	// input routing: an unselected peripheral input idles high
	always_comb begin
		gmx_sig_t sig;
		sig = SIG_NONE;
		nxt_periph_in = PERIPH_IN_RST;
		for (int p = 0; p < NUM_PINS; p++) begin
			sig = gmx_pin_signal(p, func_select[p]);
			if (sig != SIG_NONE && gmx_sig_kind(sig) != KIND_OUT) begin
				nxt_periph_in[sig] = pad_sync_ff[p];
			end
		end
	end

	// pad drivers; clocks pass through mclk, so only clocks well below it come out clean
	always_ff @(posedge mclk) begin
		if (reset) begin
			pad_out_ff <= PAD_OUT_RST;
			pad_oe_ff <= DIR_RST;
			pull_ff <= PULL_RST;
		end else begin
			pad_out_ff <= nxt_pad_out;
			pad_oe_ff <= nxt_pad_oe;
			pull_ff <= pull_enable_cfg & ~INPUT_ONLY_PINS;
		end
	end

	// peripheral inputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			periph_in_ff <= PERIPH_IN_RST;
		end else begin
			periph_in_ff <= nxt_periph_in;
		end
	end

	// interrupt detector sees the synchronised level in every mode
	assign irq_bus.level = pad_sync_ff;
	assign irq_bus.trigger_kind_cfg = trigger_kind_select;
	assign irq_bus.dual_edge_cfg = dual_edge_select;
	assign irq_bus.polarity_cfg = polarity_select;
	assign irq_bus.enable = irq_enable_mask;
	assign irq_bus.clear = irq_clear;

	gmx_irq_detect u_detect (
		.mclk(mclk),
		.reset(reset),
		.irq(irq_bus.det)
	);

	// wake request follows the raw flag of each wake pin whose wake_enable bit is set
	always_ff @(posedge mclk) begin
		if (reset) begin
			wake_ff <= '0;
		end else begin
			for (int w = 0; w < NUM_WAKE; w++) begin
				wake_ff[w] <= wake_enable[w] & irq_bus.raw[WAKE_PIN[w]];
			end
		end
	end

	assign pad_out = pad_out_ff;
	assign pad_oe = pad_oe_ff;
	assign pad_pull_en = pull_ff;
	assign gpio_in_data = gpio_in_ff;
	assign periph_in = periph_in_ff;
	assign raw_irq_flags = irq_bus.raw;
	assign masked_irq_flags = irq_bus.masked;
	assign irq_line = irq_bus.irq;
	assign wake_req = wake_ff;

	input_only_a: assert property (@(posedge mclk) disable iff (reset)
		(func_select[12] == FSEL_GPIO && func_select[13] == FSEL_GPIO) |=> (pad_oe_ff[13:12] == 2'h0))
		else $error("input-only pin driven in gpio mode");
	reset_input_a: assert property (@(posedge mclk)
		reset |=> (pad_oe_ff == DIR_RST && pull_ff == PULL_RST))
		else $error("pins not in input mode after reset");
	gpio_drive_a: assert property (@(posedge mclk) disable iff (reset)
		(func_select[7] == FSEL_GPIO && direction_select[7]) |=> (pad_oe_ff[7] && pad_out_ff[7] == $past(gpio_out_data[7])))
		else $error("gpio output not driven");
	core_clk_a: assert property (@(posedge mclk) disable iff (reset)
		(func_select[0] == FSEL_ALT_C && !core_clock_pin_enable) |=> !pad_oe_ff[0])
		else $error("core clock driven while disabled");
	pwm_pin_a: assert property (@(posedge mclk) disable iff (reset)
		(func_select[4] == FSEL_ALT_C) |=> (pad_oe_ff[4] && pad_out_ff[4] == $past(periph_out[SIG_PWM_A])))
		else $error("pwm source not on its pin");
	sync_path_a: assert property (@(posedge mclk) disable iff (reset)
		$past(reset) == 1'b0 ##0 $past(reset, 2) == 1'b0 ##0 $past(reset, 3) == 1'b0 |-> gpio_in_ff == $past(pad_in, 3))
		else $error("pin level not seen after three cycles");
	cover_alt_c: cover property (@(posedge mclk) disable iff (reset) func_select[2] == FSEL_ALT_A ##1 pad_oe_ff[2]);
	cover_wake_c: cover property (@(posedge mclk) disable iff (reset) wake_ff != '0);

endmodule : gmx_pin_mux

/* File: bench/gmx_pad_world.sv */
// pad-side model: outside drivers, pull resistors and floating pads
`timescale 1ns/10ps
module gmx_pad_world import gmx_pkg::*; (
	// clock and pads as the block drives them
	input wire logic mclk,
	input wire logic [NUM_PINS-1:0] pad_out,
	input wire logic [NUM_PINS-1:0] pad_oe,
	input wire logic [NUM_PINS-1:0] pad_pull_en,
	// outside devices
	input wire logic [NUM_PINS-1:0] ext_level,
	input wire logic [NUM_PINS-1:0] ext_drive,
	// resolved pad level
	output logic [NUM_PINS-1:0] pad_in
);
	// pins 9 to 11 pull up, the others pull down
	localparam logic [NUM_PINS-1:0] PULL_UP = 26'h000_0e00;
	logic float_ff = 1'b0;
	// a floating pad wanders, so it flips every cycle instead of keeping its last value
	always @(negedge mclk) begin
		float_ff <= ~float_ff;
	end
	// the block's driver wins; the delay keeps pad changes off the sampling edge
	assign #2 pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_level)
		| (~pad_oe & ~ext_drive & ((pad_pull_en & PULL_UP) | (~pad_pull_en & {NUM_PINS{float_ff}})));
endmodule : gmx_pad_world

/* File: bench/gmx_pin_mux_tb.sv */
// self-checking bench for the pin mux, compared every cycle with a reference model
`timescale 1ns/10ps
module gmx_pin_mux_tb import gmx_pkg::*; ();
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, pull_en, gout, dir, pcfg, gin, trig, dual, pol, ien, iclr;
	logic [NUM_PINS-1:0] raw, msk, ext_level, ext_drive, oe_ff, out_ff, pull_ff, raw_ff, msk_ff;
	logic [NUM_PINS-1:0] sy1_ff, sy2_ff, sy3_ff;
	logic [NUM_PINS-1:0][2:0] fsel;
	logic [NUM_SIG-1:0] pout, poe, pin, pin_ff;
	logic [NUM_WAKE-1:0] wen, wake, wake_ff;
	logic core_en, xtal_en, irq_line;
	int mismatches = 0;
	int n_compared = 0;
	bit chk_pad = 0;
	bit chk_irq = 0;
	bit [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
	logic [2:0] codes [7] = '{FSEL_ALT_A, FSEL_ALT_B, FSEL_ALT_C, 3'h2, 3'h3, 3'h6, 3'h7};

	gmx_pin_mux DUT (.mclk(mclk), .reset(reset), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_en(pull_en), .func_select(fsel), .gpio_out_data(gout), .direction_select(dir),
		.pull_enable_cfg(pcfg), .core_clock_pin_enable(core_en), .crystal_pin_enable(xtal_en),
		.gpio_in_data(gin), .periph_out(pout), .periph_oe(poe), .periph_in(pin), .trigger_kind_select(trig),
		.dual_edge_select(dual), .polarity_select(pol), .irq_enable_mask(ien), .irq_clear(iclr),
		.raw_irq_flags(raw), .masked_irq_flags(msk), .irq_line(irq_line), .wake_enable(wen), .wake_req(wake));
	gmx_pad_world pads (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pull_en),
		.ext_level(ext_level), .ext_drive(ext_drive), .pad_in(pad_in));

	initial forever #12.5 mclk = ~mclk;

	function automatic logic [NUM_PINS-1:0] rnd();
		return NUM_PINS'($urandom);
	endfunction : rnd

	// pad class of each signal, as in the package: 0 in, 1 out, 2 two-way, 3 open drain
	function automatic int kind_of(input gmx_sig_t s);
		case (s)
			SIG_UART_CTS, SIG_UART_RXD, SIG_SPI_DIN, SIG_MIC_DIN, SIG_DBG_CLK, SIG_NONE: return 0;
			SIG_SPI_CLK, SIG_SPI_SEL_ONE, SIG_DBG_DAT: return 2;
			SIG_I2C_ONE_CLK, SIG_I2C_ONE_DAT, SIG_I2C_TWO_CLK, SIG_I2C_TWO_DAT: return 3;
			default: return 1;
		endcase
	endfunction : kind_of

	// trigger match from the current and previous synchronised level
	function automatic logic [NUM_PINS-1:0] match_of(input logic [NUM_PINS-1:0] cur, prv);
		for (int p = 0; p < NUM_PINS; p++) begin
			if (trig[p]) match_of[p] = cur[p] == pol[p];
			else if (dual[p]) match_of[p] = cur[p] != prv[p];
			else match_of[p] = pol[p] ? cur[p] & ~prv[p] : prv[p] & ~cur[p];
		end
	endfunction : match_of

	// reference model, stepped on every rising edge with the inputs the block samples there
	always @(posedge mclk) begin
		gmx_sig_t s;
		int k;
		logic [2:0] sl;
		logic gated;
		wake_ff = wen & raw_ff[13:9];
		raw_ff = (raw_ff & ~iclr) | match_of(sy2_ff, sy3_ff);
		msk_ff = raw_ff & ien;
		pull_ff = pcfg & ~INPUT_ONLY_PINS;
		pin_ff = '1;
		for (int p = 0; p < NUM_PINS; p++) begin
			sl = fsel[p];
			s = PIN_MAP[p][sl == FSEL_ALT_A ? 0 : sl == FSEL_ALT_B ? 1 : 2];
			k = kind_of(s);
			gated = (s == SIG_CORE_CLK && !core_en) || (s == SIG_XTAL_CLK && !xtal_en);
			oe_ff[p] = 1'b0;
			out_ff[p] = pout[s];
			if (sl == FSEL_GPIO) begin
				oe_ff[p] = dir[p] & ~INPUT_ONLY_PINS[p];
				out_ff[p] = gout[p];
			end else if (sl inside {FSEL_ALT_A, FSEL_ALT_B, FSEL_ALT_C}) begin
				oe_ff[p] = k == 1 ? !gated : k == 2 ? poe[s] : k == 3 ? poe[s] & ~pout[s] : 1'b0;
				if (k == 3) out_ff[p] = 1'b0;
				if (k != 1 && s != SIG_NONE) pin_ff[s] = sy2_ff[p];
			end
		end
		sy3_ff = sy2_ff;
		sy2_ff = sy1_ff;
		sy1_ff = pad_in;
	end

	task automatic cmp_pins(input logic [NUM_PINS-1:0] got, input logic [NUM_PINS-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_pins

	task automatic cmp_sig(input logic [NUM_SIG-1:0] got, input logic [NUM_SIG-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_sig

	task automatic cmp_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_bit

	// outputs are registered, so the falling edge sees them settled
	always @(negedge mclk) begin
		if (chk_pad) begin
			cmp_pins(pad_oe, oe_ff);
			cmp_pins(pad_out & oe_ff, out_ff & oe_ff);
			cmp_pins(pull_en, pull_ff);
			cmp_pins(gin, sy3_ff);
			cmp_sig(pin, pin_ff);
		end
		if (chk_irq) begin
			cmp_pins(raw, raw_ff);
			cmp_pins(msk, msk_ff);
			cmp_bit(irq_line, |msk_ff);
			cmp_pins(NUM_PINS'(wake), NUM_PINS'(wake_ff));
		end
	end

	// random pad and peripheral traffic with sparse one-cycle clear pulses
	task automatic step(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			#1 gout = rnd();
			dir = rnd();
			pcfg = rnd();
			ext_level = rnd();
			ext_drive = rnd();
			pout = NUM_SIG'($urandom);
			poe = NUM_SIG'($urandom);
			core_en = 1'($urandom);
			xtal_en = 1'($urandom);
			iclr = i[0] ? rnd() & rnd() : 0;
		end
	endtask : step

	// stale flags are cleared before the mask opens, so no leftover fires at once
	task automatic arm(input logic [NUM_PINS-1:0] en);
		@(posedge mclk);
		#1 ien = 0;
		iclr = 0;
		@(posedge mclk);
		#1 iclr = '1;
		@(posedge mclk);
		#1 iclr = 0;
		ien = en;
		chk_irq = 1;
	endtask : arm

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	initial begin
		{gout, dir, pcfg, trig, dual, pol, ien, iclr, ext_level, ext_drive} = 0;
		{pout, poe, wen, core_en, xtal_en} = 0;
		fsel = 0;
		void'($urandom(32'h715e));
		@(negedge mclk);
		cmp_pins(pad_oe, DIR_RST);
		cmp_pins(pad_out, PAD_OUT_RST);
		cmp_pins(pull_en, PULL_RST);
		cmp_pins(raw | msk | gin, 0);
		cmp_sig(pin, PERIPH_IN_RST);
		cmp_bit(irq_line, 1'b0);
		@(posedge mclk);
		#1 reset = 0;
		repeat (4) @(posedge mclk);
		#1 chk_pad = 1;
		$display("test reset done");
		// gpio mode: each trigger mode on all pins, then a random mix per pin
		for (int m = 0; m < 6; m++) begin
			trig = m < 5 ? {NUM_PINS{modes[m][2]}} : rnd();
			dual = m < 5 ? {NUM_PINS{modes[m][1]}} : rnd();
			pol = m < 5 ? {NUM_PINS{modes[m][0]}} : rnd();
			arm(rnd());
			wen = NUM_WAKE'($urandom);
			step(40);
			$display("test gpio trigger mode %0d done", m);
		end
		// alternate sets, unused codes, then a random selector per pin
		for (int c = 0; c < 8; c++) begin
			for (int p = 0; p < NUM_PINS; p++) fsel[p] = c < 7 ? codes[c] : 3'($urandom);
			trig = rnd();
			dual = rnd();
			pol = rnd();
			arm(rnd());
			step(30);
			$display("test selector pass %0d done", c);
		end
		complete_run();
	end

	// about 530 cycles are expected; far beyond that the run has hung
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
endmodule : gmx_pin_mux_tb
